// ---- hdl/sfr_irq_map.vh ----
/*
 * Register map, field positions, reset values and codes for the interrupt
 * enable and flag bank.
 * Assumes inclusion by the bank module alone; definitions only.
 */
`ifndef SFR_IRQ_MAP_VH
`define SFR_IRQ_MAP_VH

// ==========================================================
// Byte addresses on the bus (word per register)
`define ADDR_ENABLE      12'h000
`define ADDR_FLAG        12'h004
`define ADDR_STATUS      12'h008
`define ADDR_MASK        12'h00C
`define ADDR_MODE        12'h010
`define ADDR_DEC_BITS    12

// ==========================================================
// Field positions in both 16-bit registers
`define BIT_WDOG         0
`define BIT_OSC          1
`define BIT_VACANT       3
`define BIT_PIN          4
`define BIT_MB_IN        6
`define BIT_MB_OUT       7

// ==========================================================
// Writable positions, reset values
`define LOW_RW_MASK      8'hDB
`define ENABLE_RESET     8'h00
`define FLAG_RESET       8'h82

// ==========================================================
// System vector codes that clear a mailbox flag on read
`define VEC_MB_IN        4'h6
`define VEC_MB_OUT       4'h8

// ==========================================================
// Event status bits (one per source in the low byte)
`define STATUS_W         8

// ==========================================================
// AHB codes
`define HTRANS_NONSEQ    2'h2
`define HSIZE_BYTE       3'h0
`define HSIZE_HALF       3'h1

`endif

// ---- hdl/flag_cell.v ----
/*
 * One interrupt-flag bit: hardware set, hardware clear, software write.
 * Assumes all requests arrive on hclk; single-cycle pulses.
 */
`timescale 1ns/1ps
module flag_cell #(
  parameter RESET_VAL = 1'b0
) (
  input  wire hclk,
  input  wire hresetn,
  input  wire set_pulse,
  input  wire clr_pulse,
  input  wire wr_en,
  input  wire wr_val,
  output reg  q
);

  // ==========================================================
  // Set wins over any clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RESET_VAL;
    end else if (set_pulse) begin
      q <= 1'b1;
    end else if (wr_en) begin
      q <= wr_val;
    end else if (clr_pulse) begin
      q <= 1'b0;
    end
  end

endmodule

// ---- hdl/pin_sync.v ----
/*
 * Three-stage synchroniser with agreement filter for one external level.
 * Assumes the input is asynchronous to hclk.
 */
`timescale 1ns/1ps
module pin_sync (
  input  wire hclk,
  input  wire hresetn,
  input  wire async_in,
  output reg  level,
  output wire rise
);

  reg s1;
  reg s2;
  reg s3;

  // ==========================================================
  // Only s2 reads s1; level follows once s2 and s3 agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

  assign rise = (s2 == s3) && s3 && !level;

endmodule

// ---- hdl/sfr_interrupt_enable_flag_bank.v ----
/*
 * Interrupt enable and interrupt flag register pair, AHB-Lite slave.
 * Assumes: one AHB-Lite master, word or smaller single transfers, and
 * single-cycle event pulses from the sources on hclk, except the pin.
 */
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "sfr_irq_map.vh"
module sfr_interrupt_enable_flag_bank (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        mailbox_width_select,
  input  wire        mb_out_taken,
  input  wire        mb_out_word0_written,
  input  wire        mb_out_word1_written,
  input  wire        mb_in_word0_filled,
  input  wire        mb_in_word1_filled,
  input  wire        mb_in_word0_read,
  input  wire        mb_in_word1_read,
  input  wire        vector_read,
  input  wire [3:0]  vector_value,
  input  wire        nmi_pin,
  input  wire        vacant_access,
  input  wire        osc_fault,
  input  wire        watchdog_event,
  input  wire        watchdog_interval_mode,
  output wire        mailbox_out_req,
  output wire        mailbox_in_req,
  output wire        pin_nmi_req,
  output wire        vacant_access_req,
  output wire        osc_fault_req,
  output wire        watchdog_req,
  output wire        watchdog_action,
  output wire        irq
);

  // ==========================================================
  // Bus capture
  reg        ph_wr;
  reg        ph_rd;
  reg [11:0] ph_addr;
  reg [1:0]  ph_lanes;

  wire       take = hsel && hready && (htrans == `HTRANS_NONSEQ);

  // Byte lanes of the 16-bit register within the 32-bit word; a byte at
  // offset one lands on the upper half, which has no storage
  reg [1:0] lanes_now;
  always @* begin
    lanes_now = 2'b11;
    case (hsize)
      `HSIZE_BYTE: begin
        case (haddr[1:0])
          2'b00:   lanes_now = 2'b01;
          2'b01:   lanes_now = 2'b10;
          default: lanes_now = 2'b00;
        endcase
      end
      `HSIZE_HALF: begin
        if (haddr[1]) begin
          lanes_now = 2'b00;
        end else begin
          lanes_now = 2'b11;
        end
      end
      default: begin
        lanes_now = 2'b11;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr    <= 1'b0;
      ph_rd    <= 1'b0;
      ph_addr  <= 12'h000;
      ph_lanes <= 2'b00;
    end else begin
      ph_wr    <= take && hwrite;
      ph_rd    <= take && !hwrite;
      ph_addr  <= {haddr[`ADDR_DEC_BITS-1:2], 2'b00};
      ph_lanes <= lanes_now;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire wr_lo = ph_wr && ph_lanes[0];
  wire wr_en_lo  = wr_lo && (ph_addr == `ADDR_ENABLE);
  wire wr_flg_lo = wr_lo && (ph_addr == `ADDR_FLAG);
  wire wr_mask   = wr_lo && (ph_addr == `ADDR_MASK);

  // ==========================================================
  // Enable register: only writable positions ever load
  reg [7:0] enable_lo;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_lo <= `ENABLE_RESET;
    end else if (wr_en_lo) begin
      // Upper byte has no storage, so its writes vanish
      enable_lo <= hwdata[7:0] & `LOW_RW_MASK;
    end
  end
  wire [15:0] interrupt_enable_bits = {8'h00, enable_lo};

  wire mailbox_out_int_enable   = enable_lo[`BIT_MB_OUT];
  wire mailbox_in_int_enable    = enable_lo[`BIT_MB_IN];
  wire pin_nmi_int_enable       = enable_lo[`BIT_PIN];
  wire vacant_access_int_enable = enable_lo[`BIT_VACANT];
  wire osc_fault_int_enable     = enable_lo[`BIT_OSC];
  wire watchdog_int_enable      = enable_lo[`BIT_WDOG];

  // ==========================================================
  // Mailbox progress trackers for 32-bit mode
  reg out_w0;
  reg out_w1;
  reg in_f0;
  reg in_f1;
  reg in_r0;
  reg in_r1;

  wire mb_out_clr;
  wire mb_in_set;
  wire mb_in_clr;

  assign mb_out_clr = !mailbox_width_select ? mb_out_word0_written :
    ((out_w0 || mb_out_word0_written) &&
     (out_w1 || mb_out_word1_written));
  assign mb_in_set = !mailbox_width_select ? mb_in_word0_filled :
    ((in_f0 || mb_in_word0_filled) && (in_f1 || mb_in_word1_filled));
  assign mb_in_clr = !mailbox_width_select ? mb_in_word0_read :
    ((in_r0 || mb_in_word0_read) && (in_r1 || mb_in_word1_read));

  // Trackers stay clear in 16-bit mode, so a stray half never completes
  // a later 32-bit pair
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_w0 <= 1'b0;
      out_w1 <= 1'b0;
    end else begin
      out_w0 <= mailbox_width_select && !mb_out_clr &&
                (out_w0 || mb_out_word0_written);
      out_w1 <= mailbox_width_select && !mb_out_clr &&
                (out_w1 || mb_out_word1_written);
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_f0 <= 1'b0;
      in_f1 <= 1'b0;
      in_r0 <= 1'b0;
      in_r1 <= 1'b0;
    end else begin
      in_f0 <= mailbox_width_select && !mb_in_set &&
               (in_f0 || mb_in_word0_filled);
      in_f1 <= mailbox_width_select && !mb_in_set &&
               (in_f1 || mb_in_word1_filled);
      in_r0 <= mailbox_width_select && !mb_in_clr &&
               (in_r0 || mb_in_word0_read);
      in_r1 <= mailbox_width_select && !mb_in_clr &&
               (in_r1 || mb_in_word1_read);
    end
  end

  // ==========================================================
  // Flag register cells
  wire pin_rise;
  pin_sync u_pin_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (nmi_pin),
    .level    (),
    .rise     (pin_rise)
  );

  wire vec_out_clr = vector_read && (vector_value == `VEC_MB_OUT);
  wire vec_in_clr  = vector_read && (vector_value == `VEC_MB_IN);

  wire [7:0] flag_set;
  wire [7:0] flag_clr;
  wire [7:0] flag_q;
  assign flag_set[`BIT_MB_OUT] = mb_out_taken;
  assign flag_clr[`BIT_MB_OUT] = mb_out_clr || vec_out_clr;
  assign flag_set[`BIT_MB_IN]  = mb_in_set;
  assign flag_clr[`BIT_MB_IN]  = mb_in_clr || vec_in_clr;
  assign flag_set[5]           = 1'b0;
  assign flag_clr[5]           = 1'b0;
  assign flag_set[`BIT_PIN]    = pin_rise;
  assign flag_clr[`BIT_PIN]    = 1'b0;
  assign flag_set[`BIT_VACANT] = vacant_access;
  assign flag_clr[`BIT_VACANT] = 1'b0;
  assign flag_set[2]           = 1'b0;
  assign flag_clr[2]           = 1'b0;
  assign flag_set[`BIT_OSC]    = osc_fault;
  assign flag_clr[`BIT_OSC]    = 1'b0;
  assign flag_set[`BIT_WDOG]   = watchdog_event;
  assign flag_clr[`BIT_WDOG]   = 1'b0;

  // Patterns as vectors, so each cell picks exactly its own bit
  localparam [7:0] FLAG_RST = `FLAG_RESET;
  localparam [7:0] FLAG_RW  = `LOW_RW_MASK;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_flag
      if (FLAG_RW[g]) begin : gen_cell
        flag_cell #(
          .RESET_VAL (FLAG_RST[g])
        ) u_cell (
          .hclk      (hclk),
          .hresetn   (hresetn),
          .set_pulse (flag_set[g]),
          .clr_pulse (flag_clr[g]),
          .wr_en     (wr_flg_lo),
          .wr_val    (hwdata[g]),
          .q         (flag_q[g])
        );
      end else begin : gen_zero
        assign flag_q[g] = 1'b0;
      end
    end
  endgenerate

  wire [15:0] interrupt_flag_bits = {8'h00, flag_q};

  // ==========================================================
  // Per-source requests: flag and enable together
  assign mailbox_out_req   = flag_q[`BIT_MB_OUT] && mailbox_out_int_enable;
  assign mailbox_in_req    = flag_q[`BIT_MB_IN] && mailbox_in_int_enable;
  assign pin_nmi_req       = flag_q[`BIT_PIN] && pin_nmi_int_enable;
  assign vacant_access_req = flag_q[`BIT_VACANT] && vacant_access_int_enable;
  assign osc_fault_req     = flag_q[`BIT_OSC] && osc_fault_int_enable;
  // Watchdog mode acts regardless of the enable
  assign watchdog_req    = flag_q[`BIT_WDOG] && watchdog_interval_mode &&
                           watchdog_int_enable;
  assign watchdog_action = flag_q[`BIT_WDOG] && !watchdog_interval_mode;

  // ==========================================================
  // Sticky event status, read-to-clear, with mask
  reg  [`STATUS_W-1:0] status;
  reg  [`STATUS_W-1:0] mask;
  wire                 rd_status = ph_rd && (ph_addr == `ADDR_STATUS);
  // Clear only the bits that the read reported, so an event landing
  // while the read is in flight is not lost
  wire [`STATUS_W-1:0] status_seen = rd_status ? hrdata[`STATUS_W-1:0] :
                                                 8'h00;
  wire [`STATUS_W-1:0] next_status = (status & ~status_seen) |
                                     (flag_set & `LOW_RW_MASK);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= 8'h00;
      mask   <= 8'h00;
    end else begin
      status <= next_status;
      if (wr_mask) begin
        mask <= hwdata[7:0];
      end
    end
  end

  assign irq = |(status & mask);

  // ==========================================================
  // Read data, registered in the data phase
  reg [31:0] next_hrdata;
  always @* begin
    next_hrdata = 32'h0000_0000;
    case ({haddr[`ADDR_DEC_BITS-1:2], 2'b00})
      `ADDR_ENABLE: begin
        next_hrdata = {16'h0000, interrupt_enable_bits};
      end
      `ADDR_FLAG: begin
        next_hrdata = {16'h0000, interrupt_flag_bits};
      end
      `ADDR_STATUS: begin
        next_hrdata = {24'h000000, status};
      end
      `ADDR_MASK: begin
        next_hrdata = {24'h000000, mask};
      end
      `ADDR_MODE: begin
        next_hrdata = {30'h0, watchdog_interval_mode, mailbox_width_select};
      end
      default: begin
        next_hrdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // Software should use read-modify-write on the watchdog enable

endmodule

// ---- tb/sfr_bank_checker.sv ----
/* Assertions on the ports of the interrupt enable and flag bank.
   Assumes the bind below; hready is fed back from hreadyout. */
`timescale 1ns/1ps
module sfr_bank_checker (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        mailbox_width_select,
  input wire        mb_out_taken,
  input wire        mb_out_word0_written,
  input wire        mb_in_word0_filled,
  input wire        mb_in_word1_filled,
  input wire        mb_in_word0_read,
  input wire        vector_read,
  input wire [3:0]  vector_value,
  input wire        watchdog_event,
  input wire        watchdog_interval_mode,
  input wire        mailbox_out_req,
  input wire        mailbox_in_req,
  input wire        osc_fault_req,
  input wire        watchdog_req,
  input wire        watchdog_action,
  input wire        irq
);
  // ========================================
  // Data phase trackers
  reg rd_ph;
  reg wr_ph;
  wire take = hsel && hready && htrans == 2'h2;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph <= 1'b0;
      wr_ph <= 1'b0;
    end else begin
      rd_ph <= take && !hwrite && haddr[11:3] == 9'h000;
      wr_ph <= take && hwrite;
    end
  end
  // ========================================
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_upper_zero: assert property (rd_ph |-> hrdata[15:8] == 8'h00)
    else $error("upper byte not zero");
  a_reserved_zero: assert property (rd_ph |->
    !hrdata[5] && !hrdata[2]) else $error("reserved bit set");
  a_wdog_req_mode: assert property (watchdog_req |->
    watchdog_interval_mode)
    else $error("watchdog request outside interval mode");
  a_wdog_action: assert property (
    watchdog_event && !watchdog_interval_mode ##1 !watchdog_interval_mode
    |-> watchdog_action) else $error("watchdog action missing");
  a_reset_quiet: assert property ($rose(hresetn) |->
    !osc_fault_req && !irq) else $error("request after reset");
  a_vec_out_clear: assert property (
    vector_read && vector_value == 4'h8 && !mb_out_taken && !wr_ph
    |=> !mailbox_out_req) else $error("out flag kept after vector read");
  a_vec_in_clear: assert property (
    vector_read && vector_value == 4'h6
    && !mb_in_word0_filled && !mb_in_word1_filled && !wr_ph
    |=> !mailbox_in_req) else $error("in flag kept after vector read");
  a_in_read_clear: assert property (
    mb_in_word0_read && !mailbox_width_select
    && !mb_in_word0_filled && !mb_in_word1_filled && !wr_ph
    |=> !mailbox_in_req) else $error("in flag kept after read");
  a_out_wr_clear: assert property (
    mb_out_word0_written && !mailbox_width_select && !mb_out_taken && !wr_ph
    |=> !mailbox_out_req) else $error("out flag kept after write");
endmodule
bind sfr_interrupt_enable_flag_bank sfr_bank_checker chk_inst (.*);

// ---- tb/sfr_interrupt_enable_flag_bank_tb.sv ----
/* Self-checking bench for the interrupt enable and flag bank.
   Assumes a zero-wait AHB-Lite slave and single-cycle event pulses. */
`timescale 1ns/1ps
module sfr_interrupt_enable_flag_bank_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic wim = 0, mws = 0, nmi = 0;
  logic [31:0] haddr = 0, hwdata = 0, r, d;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] vv = 0;
  logic [10:0] ev = 0;
  logic [7:0] en = 0, fl = 8'h82;
  wire hready, hresp, irq, wda;
  wire [31:0] hrdata;
  wire [5:0] rq;
  integer n_fail = 0, samples_checked = 0, i;
  always #10 hclk = ~hclk;
  sfr_interrupt_enable_flag_bank sfr_interrupt_enable_flag_bank_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .mailbox_width_select(mws), .mb_out_taken(ev[3]),
    .mb_out_word0_written(ev[4]), .mb_out_word1_written(ev[5]),
    .mb_in_word0_filled(ev[6]), .mb_in_word1_filled(ev[7]),
    .mb_in_word0_read(ev[8]), .mb_in_word1_read(ev[9]),
    .vector_read(ev[10]), .vector_value(vv), .nmi_pin(nmi),
    .vacant_access(ev[0]), .osc_fault(ev[1]), .watchdog_event(ev[2]),
    .watchdog_interval_mode(wim), .mailbox_out_req(rq[5]),
    .mailbox_in_req(rq[4]), .pin_nmi_req(rq[3]),
    .vacant_access_req(rq[2]), .osc_fault_req(rq[1]),
    .watchdog_req(rq[0]), .watchdog_action(wda), .irq(irq));
  // ========================================
  // Checking and bus tasks
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [31:0] s, input [31:0] e, input string nm);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Model: request is flag and enable, watchdog also needs interval mode
  // Waits past the edge so that writes landing on it have settled
  task cq;
    #1;
    d = {26'h0, fl[7] & en[7], fl[6] & en[6], fl[4] & en[4],
         fl[3] & en[3], fl[1] & en[1], fl[0] & en[0] & wim};
    chk(rq, d, "requests");
    chk(wda, fl[0] & !wim, "wdog action");
    chk(hresp, 0, "response");
  endtask
  task edge_rdy;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hready !== 1'b1 && i < 20);
    if (hready !== 1'b1) begin
      n_fail++;
      complete_run;
    end
  endtask
  task bus(input [11:0] a, input w, input [2:0] sz, input [31:0] dv);
    hsel <= 1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    edge_rdy;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= dv;
    edge_rdy;
    r = hrdata;
  endtask
  task rd(input [11:0] a, input [31:0] e, input string nm);
    bus(a, 0, 3'h2, 32'h0);
    chk(r, e, nm);
  endtask
  task pulse(input integer k);
    ev[k] <= 1;
    @(posedge hclk);
    ev[k] <= 0;
    @(posedge hclk);
  endtask
  // ========================================
  // Scenarios
  initial begin
    r = $urandom(37);
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    rd(12'h000, 32'h0, "enable");
    rd(12'h004, 32'h82, "flag");
    cq;
    repeat (4) begin
      d = $urandom;
      bus(12'h000, 1, 3'h2, d);
      en = d[7:0] & 8'hDB;
      rd(12'h000, {24'h0, en}, "enable");
    end
    bus(12'h001, 1, 3'h0, 32'hFFFFFFFF);
    rd(12'h000, {24'h0, en}, "byte one");
    bus(12'h000, 1, 3'h0, 32'h000000FF);
    en = 8'hDB;
    rd(12'h000, 32'hDB, "byte zero");
    cq;
    bus(12'h004, 1, 3'h2, 32'h0);
    fl = 0;
    cq;
    pulse(0);
    pulse(1);
    fl = 8'h0A;
    rd(12'h004, 32'h0A, "flag");
    cq;
    wim <= 1;
    pulse(2);
    fl[0] = 1;
    cq;
    wim <= 0;
    @(posedge hclk);
    cq;
    // Clear the watchdog flag, then raise it again in watchdog mode
    bus(12'h004, 1, 3'h2, {24'h0, fl & 8'hFE});
    fl[0] = 0;
    cq;
    pulse(2);
    fl[0] = 1;
    cq;
    // Read-modify-write keeps the neighbours intact
    en = en & 8'hFE;
    bus(12'h000, 1, 3'h2, {24'h0, en});
    cq;
    wim <= 1;
    pulse(3);
    fl[7] = 1;
    cq;
    pulse(4);
    fl[7] = 0;
    cq;
    pulse(6);
    fl[6] = 1;
    cq;
    pulse(8);
    fl[6] = 0;
    cq;
    mws <= 1;
    pulse(6);
    cq;
    pulse(7);
    fl[6] = 1;
    pulse(8);
    cq;
    pulse(9);
    fl[6] = 0;
    cq;
    pulse(3);
    fl[7] = 1;
    pulse(5);
    cq;
    pulse(4);
    fl[7] = 0;
    cq;
    mws <= 0;
    pulse(3);
    pulse(6);
    fl[7:6] = 2'b11;
    vv <= 4'h8;
    pulse(10);
    fl[7] = 0;
    cq;
    vv <= 4'h6;
    pulse(10);
    fl[6] = 0;
    cq;
    nmi <= 1;
    i = 0;
    while (rq[3] !== 1'b1 && i < 20) begin
      @(posedge hclk);
      i++;
    end
    if (rq[3] !== 1'b1) begin
      n_fail++;
      complete_run;
    end
    fl[4] = 1;
    cq;
    bus(12'h00C, 1, 3'h2, 32'h08);
    rd(12'h00C, 32'h08, "mask");
    bus(12'h008, 0, 3'h2, 32'h0);
    @(posedge hclk);
    chk(irq, 0, "irq idle");
    pulse(0);
    chk(irq, 1, "irq raised");
    rd(12'h008, 32'h08, "status");
    @(posedge hclk);
    chk(irq, 0, "irq cleared");
    bus(12'h00C, 1, 3'h2, 32'h0);
    pulse(0);
    chk(irq, 0, "irq masked");
    rd(12'h020, 32'h0, "unmapped");
    rd(12'h010, {30'h0, wim, mws}, "mode");
    bus(12'h004, 1, 3'h2, 32'hFFFFFFFF);
    fl = 8'hDB;
    rd(12'h004, 32'hDB, "flag all");
    cq;
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    n_fail++;
    complete_run;
  end
endmodule
